// ---- src/sds_consts.svh ----
// constants for the status display sequencer
`ifndef SDS_CONSTS_SVH
`define SDS_CONSTS_SVH
`define SDS_CLK_HZ          10000000
`define SDS_BLINK_HALF_MS   50
`define SDS_BLINK_CYC       ((`SDS_CLK_HZ / 1000) * `SDS_BLINK_HALF_MS)
`define SDS_WDOG_MS         100
`define SDS_WDOG_CYC        ((`SDS_CLK_HZ / 1000) * `SDS_WDOG_MS)
`define SDS_WDOG_PULSE      16
`define SDS_NODE_MAX        15
`define SDS_SEG_ALL         7'h7f
`define SDS_SEG_BLANK       7'h00
`endif

// ---- src/sds_pkg.sv ----
// types for the status display sequencer
`default_nettype none
package sds_pkg;
   typedef enum logic [3:0] {
      SDS_ERR_NONE   = 4'h0,
      SDS_ERR_SERIAL = 4'h1,
      SDS_ERR_CAN    = 4'h2,
      SDS_ERR_NOMEM  = 4'h3,
      SDS_ERR_MEMTST = 4'h4,
      SDS_ERR_ERASE  = 4'h5,
      SDS_ERR_UPDATE = 4'h6,
      SDS_ERR_NOFW   = 4'h7
   } sds_err_t;
   typedef enum logic [2:0] {
      SDS_ST_RESET = 3'b000,
      SDS_ST_BOOT  = 3'b001,
      SDS_ST_START = 3'b011,
      SDS_ST_RUN   = 3'b010,
      SDS_ST_RAM   = 3'b110,
      SDS_ST_ERASE = 3'b111,
      SDS_ST_WRITE = 3'b101
   } sds_state_t;
endpackage : sds_pkg
`default_nettype wire

// ---- src/sds_sync.sv ----
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module sds_sync (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic din,
   output logic      dout
);
   logic meta_reg;
   logic s2_reg;
   logic s3_reg;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         meta_reg <= 1'b0;
         s2_reg   <= 1'b0;
         s3_reg   <= 1'b0;
         dout     <= 1'b0;
      end else begin
         meta_reg <= din;
         s2_reg   <= meta_reg;
         s3_reg   <= s2_reg;
         if (s2_reg == s3_reg) begin
            dout <= s3_reg;
         end
      end
   end
endmodule : sds_sync
`default_nettype wire

// ---- src/sds_status_display.sv ----
// front-panel status display sequencer with system watchdog
`timescale 1ns/100ps
`default_nettype none
`include "sds_consts.svh"
module sds_status_display (
   input  wire logic            clk,
   input  wire logic            reset,
   input  wire logic            bootDone,
   input  wire logic            fwStarted,
   input  wire logic            updateReq,
   input  wire logic            ramTestDone,
   input  wire logic            eraseDone,
   input  wire logic            writeDone,
   input  wire logic [7:0]      nodeNumber,
   input  wire sds_pkg::sds_err_t errCode,
   input  wire logic            wdogKick,
   input  wire logic            wdogEnable,
   output logic [6:0]           segOut_reg,
   output logic                 dotOut_reg,
   output logic                 softReset_reg
);
   // -----------------------------------------------------------
   // kick synchroniser (external firmware domain)
   // -----------------------------------------------------------
   wire kickSync;
   sds_sync u_kick (
      .clk   (clk),
      .reset (reset),
      .din   (wdogKick),
      .dout  (kickSync)
   );
   logic kickLast_reg;
   wire  kickEdge = kickSync & ~kickLast_reg;

   // -----------------------------------------------------------
   // sequence state
   // -----------------------------------------------------------
   sds_pkg::sds_state_t state_reg;
   sds_pkg::sds_state_t state_next;
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         sds_pkg::SDS_ST_RESET: state_next = sds_pkg::SDS_ST_BOOT;
         sds_pkg::SDS_ST_BOOT:  if (bootDone) state_next = sds_pkg::SDS_ST_START;
         sds_pkg::SDS_ST_START: if (fwStarted) state_next = sds_pkg::SDS_ST_RUN;
         sds_pkg::SDS_ST_RUN:   if (updateReq) state_next = sds_pkg::SDS_ST_RAM;
         sds_pkg::SDS_ST_RAM:   if (ramTestDone) state_next = sds_pkg::SDS_ST_ERASE;
         sds_pkg::SDS_ST_ERASE: if (eraseDone) state_next = sds_pkg::SDS_ST_WRITE;
         sds_pkg::SDS_ST_WRITE: if (writeDone) state_next = sds_pkg::SDS_ST_RESET;
         default:               state_next = sds_pkg::SDS_ST_RESET;
      endcase
   end

   // -----------------------------------------------------------
   // symbol selection
   // -----------------------------------------------------------
   // segment order {g,f,e,d,c,b,a}
   function automatic logic [6:0] hexSeg(input logic [3:0] v);
      case (v)
         4'h1: hexSeg = 7'h06;
         4'h2: hexSeg = 7'h5b;
         4'h3: hexSeg = 7'h4f;
         4'h4: hexSeg = 7'h66;
         4'h5: hexSeg = 7'h6d;
         4'h6: hexSeg = 7'h7d;
         4'h7: hexSeg = 7'h07;
         4'h8: hexSeg = 7'h7f;
         4'h9: hexSeg = 7'h6f;
         4'ha: hexSeg = 7'h77;
         4'hb: hexSeg = 7'h7c;
         4'hc: hexSeg = 7'h39;
         4'hd: hexSeg = 7'h5e;
         4'he: hexSeg = 7'h79;
         4'hf: hexSeg = 7'h71;
         default: hexSeg = 7'h3f;
      endcase
   endfunction : hexSeg

   localparam logic [6:0] SEG_B = 7'h7c;
   localparam logic [6:0] SEG_J = 7'h1e;
   localparam logic [6:0] SEG_M = 7'h37;
   localparam logic [6:0] SEG_R = 7'h50;
   localparam logic [6:0] SEG_F = 7'h71;
   localparam logic [6:0] SEG_L = 7'h38;
   localparam logic [6:0] SEG_D = 7'h5e;
   localparam logic [6:0] SEG_C = 7'h39;
   localparam logic [6:0] SEG_S = 7'h6d;
   localparam logic [6:0] SEG_E = 7'h79;
   localparam logic [6:0] SEG_U = 7'h3e;

   wire nodeValid = (nodeNumber != 8'h00) && (nodeNumber <= 8'(`SDS_NODE_MAX));
   wire [6:0] runSeg = nodeValid ? hexSeg(nodeNumber[3:0]) : SEG_M;
   wire errActive = (errCode != sds_pkg::SDS_ERR_NONE);
   logic [6:0] errSeg;
   always_comb begin
      case (errCode)
         sds_pkg::SDS_ERR_SERIAL: errSeg = SEG_D;
         sds_pkg::SDS_ERR_CAN:    errSeg = SEG_C;
         sds_pkg::SDS_ERR_NOMEM:  errSeg = SEG_S;
         sds_pkg::SDS_ERR_MEMTST: errSeg = SEG_R;
         sds_pkg::SDS_ERR_ERASE:  errSeg = SEG_F;
         sds_pkg::SDS_ERR_UPDATE: errSeg = SEG_E;
         sds_pkg::SDS_ERR_NOFW:   errSeg = SEG_U;
         default:                 errSeg = `SDS_SEG_BLANK;
      endcase
   end
   logic [6:0] stateSeg;
   always_comb begin
      case (state_reg)
         sds_pkg::SDS_ST_RESET: stateSeg = `SDS_SEG_ALL;
         sds_pkg::SDS_ST_BOOT:  stateSeg = SEG_B;
         sds_pkg::SDS_ST_START: stateSeg = SEG_J;
         sds_pkg::SDS_ST_RUN:   stateSeg = runSeg;
         sds_pkg::SDS_ST_RAM:   stateSeg = SEG_R;
         sds_pkg::SDS_ST_ERASE: stateSeg = SEG_F;
         sds_pkg::SDS_ST_WRITE: stateSeg = SEG_L;
         default:               stateSeg = `SDS_SEG_ALL;
      endcase
   end
   wire [6:0] segNext = errActive ? errSeg : stateSeg;

   // -----------------------------------------------------------
   // decimal point blink, 50 ms half period
   // -----------------------------------------------------------
   localparam int BLINK_CYC = `SDS_BLINK_CYC;
   logic [19:0] blinkCnt_reg;
   logic        blink_reg;
   wire         blinkWrap = (blinkCnt_reg == 20'(BLINK_CYC - 1));
   wire         dotNext = errActive & ~blink_reg;

   // -----------------------------------------------------------
   // watchdog
   // -----------------------------------------------------------
   localparam int WDOG_CYC = `SDS_WDOG_CYC;
   logic [23:0] wdogCnt_reg;
   logic [4:0]  pulseCnt_reg;
   wire         wdogExpire = wdogEnable && (wdogCnt_reg == 24'(WDOG_CYC - 1));

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_reg    <= sds_pkg::SDS_ST_RESET;
         segOut_reg   <= `SDS_SEG_ALL;
         dotOut_reg   <= 1'b0;
         blinkCnt_reg <= 20'h00000;
         blink_reg    <= 1'b0;
         kickLast_reg <= 1'b0;
      end else begin
         state_reg    <= state_next;
         segOut_reg   <= segNext;
         dotOut_reg   <= dotNext;
         kickLast_reg <= kickSync;
         if (!errActive) begin
            blinkCnt_reg <= 20'h00000;
            blink_reg    <= 1'b0;
         end else if (blinkWrap) begin
            blinkCnt_reg <= 20'h00000;
            blink_reg    <= ~blink_reg;
         end else begin
            blinkCnt_reg <= blinkCnt_reg + 20'h00001;
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wdogCnt_reg   <= 24'h000000;
         pulseCnt_reg  <= 5'h00;
         softReset_reg <= 1'b0;
      end else begin
         if (!wdogEnable || kickEdge || wdogExpire) begin
            wdogCnt_reg <= 24'h000000;
         end else begin
            wdogCnt_reg <= wdogCnt_reg + 24'h000001;
         end
         if (wdogExpire) begin
            pulseCnt_reg  <= 5'(`SDS_WDOG_PULSE);
            softReset_reg <= 1'b1;
         end else if (pulseCnt_reg != 5'h00) begin
            pulseCnt_reg  <= pulseCnt_reg - 5'h01;
            softReset_reg <= (pulseCnt_reg != 5'h01);
         end else begin
            softReset_reg <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------
   // assertions
   // -----------------------------------------------------------
   a_node_digit: assert property (@(posedge clk) disable iff (reset)
      (state_reg == sds_pkg::SDS_ST_RUN && !errActive && nodeValid) |=> segOut_reg == hexSeg($past(nodeNumber[3:0])))
      else $error("node digit wrong");
   a_overflow_m: assert property (@(posedge clk) disable iff (reset)
      (state_reg == sds_pkg::SDS_ST_RUN && !errActive && !nodeValid) |=> segOut_reg == SEG_M)
      else $error("overflow symbol wrong");
   a_boot_order: assert property (@(posedge clk) disable iff (reset)
      (state_reg == sds_pkg::SDS_ST_RESET) |=> state_reg == sds_pkg::SDS_ST_BOOT)
      else $error("boot does not follow reset");
   a_boot_sym: assert property (@(posedge clk) disable iff (reset)
      (state_reg == sds_pkg::SDS_ST_BOOT && !errActive) |=> segOut_reg == SEG_B)
      else $error("boot symbol wrong");
   a_update_seq: assert property (@(posedge clk) disable iff (reset)
      (state_reg == sds_pkg::SDS_ST_WRITE && writeDone) |=> state_reg == sds_pkg::SDS_ST_RESET ##1
      state_reg == sds_pkg::SDS_ST_BOOT)
      else $error("update does not restart boot");
   a_err_blink: assert property (@(posedge clk) disable iff (reset)
      (errActive && blinkWrap) ##1 errActive |=> $changed(dotOut_reg))
      else $error("dot not toggling");
   a_err_code: assert property (@(posedge clk) disable iff (reset)
      (errCode == sds_pkg::SDS_ERR_CAN) |=> segOut_reg == SEG_C)
      else $error("error symbol wrong");
   a_wdog_fire: assert property (@(posedge clk) disable iff (reset)
      wdogExpire |=> softReset_reg [*8])
      else $error("watchdog reset missing");
   a_dot_quiet: assert property (@(posedge clk) disable iff (reset)
      !errActive |=> !dotOut_reg)
      else $error("dot lit without error");

   c_run: cover property (@(posedge clk) disable iff (reset) state_reg == sds_pkg::SDS_ST_RUN);
   c_update: cover property (@(posedge clk) disable iff (reset) state_reg == sds_pkg::SDS_ST_WRITE && writeDone);
   c_error: cover property (@(posedge clk) disable iff (reset) errActive && dotOut_reg);
   c_wdog: cover property (@(posedge clk) disable iff (reset) wdogExpire);
endmodule : sds_status_display
`default_nettype wire

// ---- verification/status_display_sequencer_bench.sv ----
// self-checking testbench for the status display sequencer
`timescale 1ns/100ps
`default_nettype none
module status_display_sequencer_bench;
   logic              clk, reset, bootDone, fwStarted, updateReq, ramTestDone, eraseDone, writeDone;
   logic [7:0]        nodeNumber;
   sds_pkg::sds_err_t errCode;
   logic              wdogKick, wdogEnable;
   logic [6:0]        segOut_reg;
   logic              dotOut_reg, softReset_reg;
   int                miscompares = 0;
   int                n_checks = 0;
   logic [6:0]        hexSeg [16] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07,
                                      7'h7f, 7'h6f, 7'h77, 7'h7c, 7'h39, 7'h5e, 7'h79, 7'h71};
   logic [6:0]        errSeg [8] = '{7'h00, 7'h5e, 7'h39, 7'h6d, 7'h50, 7'h71, 7'h79, 7'h3e};

   sds_status_display u_dut (.clk(clk), .reset(reset), .bootDone(bootDone), .fwStarted(fwStarted),
      .updateReq(updateReq), .ramTestDone(ramTestDone), .eraseDone(eraseDone), .writeDone(writeDone),
      .nodeNumber(nodeNumber), .errCode(errCode), .wdogKick(wdogKick), .wdogEnable(wdogEnable),
      .segOut_reg(segOut_reg), .dotOut_reg(dotOut_reg), .softReset_reg(softReset_reg));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] expected);
      n_checks++;
      if (seen !== expected) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, expected, seen);
      end
   endtask : check

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_of_test

   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic power_up;
      check("seg in reset", {1'b0, segOut_reg}, 8'h7f);
      check("dot in reset", {7'h0, dotOut_reg}, 8'h00);
      reset = 1'b0;
      step(3);
      check("seg boot", {1'b0, segOut_reg}, 8'h7c);
      check("dot boot", {7'h0, dotOut_reg}, 8'h00);
      fwStarted = 1'b1;
      step(3);
      fwStarted = 1'b0;
      check("fw ignored in boot", {1'b0, segOut_reg}, 8'h7c);
      bootDone = 1'b1;
      step(1);
      bootDone = 1'b0;
      step(2);
      check("seg start", {1'b0, segOut_reg}, 8'h1e);
      fwStarted = 1'b1;
      step(1);
      fwStarted = 1'b0;
      step(2);
      check("seg running", {1'b0, segOut_reg}, {1'b0, hexSeg[nodeNumber[3:0]]});
   endtask : power_up

   task automatic node_sweep;
      for (int n = 0; n < 19; n++) begin
         nodeNumber = (n == 18) ? 8'hff : 8'(n);
         step(3);
         if (n >= 1 && n <= 15) check("node digit", {1'b0, segOut_reg}, {1'b0, hexSeg[n]});
         else check("node overflow", {1'b0, segOut_reg}, 8'h37);
         check("dot running", {7'h0, dotOut_reg}, 8'h00);
      end
      nodeNumber = 8'h0a;
      step(3);
   endtask : node_sweep

   task automatic error_codes;
      for (int e = 1; e < 8; e++) begin
         errCode = sds_pkg::sds_err_t'(e[3:0]);
         step(3);
         check("error symbol", {1'b0, segOut_reg}, {1'b0, errSeg[e]});
         check("error dot on", {7'h0, dotOut_reg}, 8'h01);
         errCode = sds_pkg::SDS_ERR_NONE;
         step(3);
         check("error cleared", {1'b0, segOut_reg}, 8'h77);
         check("dot cleared", {7'h0, dotOut_reg}, 8'h00);
      end
      errCode = sds_pkg::sds_err_t'(4'h9);
      step(3);
      check("unknown error blank", {1'b0, segOut_reg}, 8'h00);
      check("unknown error dot", {7'h0, dotOut_reg}, 8'h01);
      errCode = sds_pkg::SDS_ERR_NONE;
      step(3);
      check("unknown error cleared", {1'b0, segOut_reg}, 8'h77);
      check("unknown dot cleared", {7'h0, dotOut_reg}, 8'h00);
   endtask : error_codes

   task automatic update_flow;
      eraseDone = 1'b1;
      step(3);
      eraseDone = 1'b0;
      check("stray done ignored", {1'b0, segOut_reg}, 8'h77);
      updateReq = 1'b1;
      step(1);
      updateReq = 1'b0;
      step(2);
      check("seg ram test", {1'b0, segOut_reg}, 8'h50);
      check("dot ram test", {7'h0, dotOut_reg}, 8'h00);
      ramTestDone = 1'b1;
      step(1);
      ramTestDone = 1'b0;
      step(2);
      check("seg erase", {1'b0, segOut_reg}, 8'h71);
      check("dot erase", {7'h0, dotOut_reg}, 8'h00);
      eraseDone = 1'b1;
      step(1);
      eraseDone = 1'b0;
      step(2);
      check("seg write", {1'b0, segOut_reg}, 8'h38);
      writeDone = 1'b1;
      step(1);
      writeDone = 1'b0;
      step(3);
      check("seg reboot", {1'b0, segOut_reg}, 8'h7c);
      bootDone = 1'b1;
      step(1);
      bootDone = 1'b0;
      step(2);
      check("seg restart", {1'b0, segOut_reg}, 8'h1e);
   endtask : update_flow

   task automatic watchdog_kept;
      wdogEnable = 1'b1;
      for (int i = 0; i < 40; i++) begin
         wdogKick = 1'b1;
         step(10);
         wdogKick = 1'b0;
         step(490);
         if (softReset_reg !== 1'b0) check("serviced watchdog", {7'h0, softReset_reg}, 8'h00);
      end
      check("no soft reset", {7'h0, softReset_reg}, 8'h00);
   endtask : watchdog_kept

   initial begin
      reset = 1'b1;
      {bootDone, fwStarted, updateReq, ramTestDone, eraseDone, writeDone, wdogKick, wdogEnable} = '0;
      nodeNumber = 8'h0a;
      errCode = sds_pkg::SDS_ERR_NONE;
      step(4);
      power_up();
      node_sweep();
      error_codes();
      update_flow();
      watchdog_kept();
      end_of_test();
   end
endmodule : status_display_sequencer_bench
`default_nettype wire
